// file: clk_pwr_cfg.svh
// register offsets, field codes and counts of the clock and power bank
// assumes byte addresses on a 32-bit wishbone bus, one word per register
`ifndef CLK_PWR_CFG_SVH
`define CLK_PWR_CFG_SVH

`define ADR_W          8
`define A_PCLK_ENABLE  8'h10
`define A_PCLK_DISABLE 8'h14
`define A_PCLK_STATE   8'h18
`define A_CLK_SETUP    8'h20
`define A_PWR_CMD      8'h28
`define A_PWR_SETUP    8'h2c
`define A_CLK_STATUS   8'h30

`define PERIPH_MASK    32'h0007effc
`define CLK_SETUP_MASK 32'h3fffff77
`define PWR_SETUP_BKUP 8'h01
`define PCR_CUT_BIT    0
`define PCR_WAKE_BIT   1

`define LVL_FLOAT      2'b00
`define LVL_LOW        2'b01
`define LVL_HIGH       2'b10
`define EDGE_RISE_BIT  0
`define EDGE_FALL_BIT  1

`define SRC_LF         2'b00
`define SRC_MOSC       2'b01
`define SRC_PLL        2'b10
`define CLK_DIVIDER_SEL_BYPASS    3'h0
`define CLK_DIVIDER_SEL_RSVD      3'h7
`define CLK_DIVIDER_SEL_CNT_W     6
`define OSC_DIV_LAST   3'h7

`define SYNC_W         4
`define SI_SLOW        0
`define SI_OSC         1
`define SI_WAKE        2
`define SI_ALARM       3

`endif

// file: clk_pwr_pkg.sv
// types shared by the clock and power bank and its helpers
// assumes clk_pwr_cfg.svh sits in the same folder
package clk_pwr_pkg;
`include "clk_pwr_cfg.svh"

	typedef struct packed {
		logic               cyc;
		logic               stb;
		logic               we;
		logic [3:0]         sel;
		logic [`ADR_W-1:0]  adr;
		logic [31:0]        dat;
	} wb_req_type;

	typedef struct packed {
		logic               ack;
		logic [31:0]        dat;
	} wb_rsp_type;

	typedef struct packed {
		logic [1:0] rsvd_hi;
		logic [5:0] pll_settle_count;
		logic [7:0] osc_settle_count;
		logic [1:0] clk_src_sel;
		logic [5:0] pll_factor;
		logic       rsvd7;
		logic [2:0] clk_divider_sel;
		logic       rsvd3;
		logic       mclk_out_off;
		logic       osc_run_en;
		logic       osc_bypass_sel;
	} clk_setup_type;

	typedef struct packed {
		logic [1:0] wake_edge_sel;
		logic       alarm_cut_en;
		logic       alarm_wake_en;
		logic [1:0] wake_level_sel;
		logic [1:0] power_cut_level_sel;
	} pwr_setup_type;

	typedef enum logic [1:0] {
		CUT_WAKE = 2'b01,
		CUT_OFF  = 2'b10
	} cut_state_type;

	typedef struct packed {
		logic                ack;
		logic [31:0]         rdat;
		logic [31:0]         pclk;
		clk_setup_type       cgm;
		pwr_setup_type       pmr;
		cut_state_type       cut;
		logic                cut_oe;
		logic                cut_lvl;
		logic [2:0]          div8;
		logic [7:0]          osc_cnt;
		logic [5:0]          pll_cnt;
		logic                osc_ok;
		logic                lock;
	} ctl_state_type;

	typedef struct packed {
		logic [`SYNC_W-1:0] f1;
		logic [`SYNC_W-1:0] f2;
		logic [`SYNC_W-1:0] f3;
		logic [`SYNC_W-1:0] lvl;
		logic [`SYNC_W-1:0] rise;
		logic [`SYNC_W-1:0] fall;
	} sync_state_type;

	typedef struct packed {
		logic [`CLK_DIVIDER_SEL_CNT_W-1:0] cnt;
		logic                   tick;
	} clk_divider_sel_state_type;

endpackage : clk_pwr_pkg

// file: pin_sync.sv
// three-stage synchronisers for the asynchronous pins, with edge pulses
// assumes pins may change at any time; a change counts once stages 2 and 3 agree
`timescale 1ns/1ps
`include "clk_pwr_cfg.svh"
module pin_sync (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               ce_i,
	input  wire logic [`SYNC_W-1:0] pin_i,
	output logic      [`SYNC_W-1:0] level_o,
	output logic      [`SYNC_W-1:0] rise_o,
	output logic      [`SYNC_W-1:0] fall_o
);
	import clk_pwr_pkg::*;

	sync_state_type st_q;
	sync_state_type st_d;

	// stage 1 feeds only stage 2; the filter looks at stages 2 and 3
	always_comb begin
		st_d = st_q;
		if (ce_i) begin
			st_d.f1 = pin_i;
			st_d.f2 = st_q.f1;
			st_d.f3 = st_q.f2;
			for (int i = 0; i < `SYNC_W; i++) begin
				if (st_q.f2[i] == st_q.f3[i]) begin
					st_d.lvl[i] = st_q.f3[i];
				end
			end
			st_d.rise = st_d.lvl & ~st_q.lvl;
			st_d.fall = ~st_d.lvl & st_q.lvl;
		end
		if (rst_i) begin
			st_d = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		st_q <= st_d;
	end

	assign level_o = st_q.lvl;
	assign rise_o  = st_q.rise;
	assign fall_o  = st_q.fall;
endmodule : pin_sync

// file: prescaler.sv
// power-of-two prescaler on source events, one-cycle output tick
// assumes src_ev_i is a one-cycle pulse per edge of the selected clock
`timescale 1ns/1ps
`include "clk_pwr_cfg.svh"
module prescaler (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	input  wire logic       src_ev_i,
	input  wire logic [2:0] sel_i,
	output logic            tick_o
);
	import clk_pwr_pkg::*;

	clk_divider_sel_state_type st_q;
	clk_divider_sel_state_type st_d;
	logic [`CLK_DIVIDER_SEL_CNT_W-1:0] last;

	// code n divides by 2**n; the reserved code stops the output
	always_comb begin
		last = (`CLK_DIVIDER_SEL_CNT_W'(1) << sel_i) - `CLK_DIVIDER_SEL_CNT_W'(1);
		st_d = st_q;
		if (ce_i) begin
			st_d.tick = 1'b0;
			if (sel_i == `CLK_DIVIDER_SEL_RSVD) begin
				st_d.cnt = '0;
			end else if (src_ev_i) begin
				if (st_q.cnt >= last) begin
					st_d.cnt  = '0;
					st_d.tick = 1'b1;
				end else begin
					st_d.cnt = st_q.cnt + `CLK_DIVIDER_SEL_CNT_W'(1);
				end
			end
		end
		if (rst_i) begin
			st_d = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		st_q <= st_d;
	end

	assign tick_o = st_q.tick;
endmodule : prescaler

// file: clock_gen_power_shutdown_ctrl.sv
// clock generator setup, peripheral clock gating and power-cut pin control
// assumes one 40 MHz clock, synchronous resets, slow clock and pins asynchronous
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
`include "clk_pwr_cfg.svh"

module clock_gen_power_shutdown_ctrl (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    bkup_rst_i,
	input  wire logic                    ce_i,
	input  wire clk_pwr_pkg::wb_req_type wb_i,
	output clk_pwr_pkg::wb_rsp_type      wb_o,
	input  wire logic                    slow_clk_i,
	input  wire logic                    osc_in_pin_i,
	input  wire logic                    wake_pin_i,
	input  wire logic                    rtc_alarm_i,
	output logic [31:0]                  periph_clk_en_o,
	output logic                         osc_run_en_o,
	output logic                         osc_bypass_sel_o,
	output logic                         pll_on_o,
	output logic [5:0]                   pll_factor_o,
	output logic [1:0]                   clk_src_sel_o,
	output logic                         master_clk_o,
	output logic                         mclk_out_pin_o,
	output logic                         mclk_out_pin_oe_o,
	output logic                         osc_stable_flag_o,
	output logic                         pll_lock_o,
	output logic                         power_cut_pin_o,
	output logic                         power_cut_pin_oe_o
);
	import clk_pwr_pkg::*;

	ctl_state_type      st_q;
	ctl_state_type      st_d;
	logic [`SYNC_W-1:0] pin_lvl;
	logic [`SYNC_W-1:0] pin_rise;
	logic [`SYNC_W-1:0] pin_fall;
	logic               src_ev;
	logic               req;
	logic               wr;
	logic [31:0]        wdat;
	clk_setup_type      cgm_new;
	logic [31:0]        pmr_word;
	logic               osc_load;
	logic               pll_load;
	logic               slow_tick;
	logic               osc_tick;
	logic               wake_ev;
	logic               cut_ev;
	logic               alarm_ev;
	logic               edge_ev;

	// byte lanes outside sel keep their old value
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old_v & ~m) | (new_v & m);
	endfunction : lane_merge

	// level code to {enable, value}; reserved code floats like code zero
	function automatic logic [1:0] level_drive(input logic [1:0] code);
		logic [1:0] r;
		r = 2'b00;
		unique case (code)
			`LVL_LOW:  r = 2'b10;
			`LVL_HIGH: r = 2'b11;
			default:   r = 2'b00;
		endcase
		return r;
	endfunction : level_drive

	pin_sync u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.pin_i   ({rtc_alarm_i, wake_pin_i, osc_in_pin_i, slow_clk_i}),
		.level_o (pin_lvl),
		.rise_o  (pin_rise),
		.fall_o  (pin_fall)
	);

	// source events; the core clock stands in for the pll output here
	always_comb begin
		src_ev = 1'b0;
		unique case (st_q.cgm.clk_src_sel)
			`SRC_LF:   src_ev = pin_rise[`SI_SLOW];
			`SRC_MOSC: src_ev = pin_rise[`SI_OSC] & (st_q.osc_ok | st_q.cgm.osc_bypass_sel);
			`SRC_PLL:  src_ev = st_q.lock;
			default:   src_ev = 1'b0;
		endcase
	end

	prescaler u_clk_divider_sel (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.ce_i     (ce_i),
		.src_ev_i (src_ev),
		.sel_i    (st_q.cgm.clk_divider_sel),
		.tick_o   (master_clk_o)
	);

	// bus decode; ack is one cycle long and never back to back
	always_comb begin
		req       = wb_i.cyc & wb_i.stb & ~st_q.ack;
		wr        = req & wb_i.we;
		wdat      = lane_merge(32'h0, wb_i.dat, wb_i.sel);
		cgm_new   = lane_merge(st_q.cgm, wb_i.dat, wb_i.sel) & `CLK_SETUP_MASK;
		pmr_word  = lane_merge({24'h0, st_q.pmr}, wb_i.dat, wb_i.sel);
		slow_tick = pin_rise[`SI_SLOW];
		osc_tick  = slow_tick & (st_q.div8 == `OSC_DIV_LAST);
		osc_load  = wr && wb_i.adr == `A_CLK_SETUP && cgm_new.osc_run_en
			&& !st_q.cgm.osc_run_en && cgm_new.osc_settle_count != 8'h0;
		pll_load  = wr && wb_i.adr == `A_CLK_SETUP
			&& cgm_new.pll_factor != st_q.cgm.pll_factor && cgm_new.pll_factor != 6'h0
			&& cgm_new.pll_settle_count != 6'h0;
	end

	// power-cut events; any wake source beats any cut source
	always_comb begin
		alarm_ev = pin_rise[`SI_ALARM];
		edge_ev  = (pin_rise[`SI_WAKE] & st_q.pmr.wake_edge_sel[`EDGE_RISE_BIT])
			| (pin_fall[`SI_WAKE] & st_q.pmr.wake_edge_sel[`EDGE_FALL_BIT]);
		wake_ev  = (wr && wb_i.adr == `A_PWR_CMD && wdat[`PCR_WAKE_BIT])
			| (alarm_ev & st_q.pmr.alarm_wake_en)
			| edge_ev;
		cut_ev   = (wr && wb_i.adr == `A_PWR_CMD && wdat[`PCR_CUT_BIT])
			| (alarm_ev & st_q.pmr.alarm_cut_en & ~st_q.pmr.alarm_wake_en);
	end

	// next state; resets are synchronous and applied after the enabled update, before the pin drive
	always_comb begin
		logic [1:0] drv;
		drv  = 2'b00;
		st_d = st_q;
		if (ce_i) begin
			st_d.ack  = req;
			st_d.rdat = 32'h0;
			if (req && !wb_i.we) begin
				unique case (wb_i.adr)
					`A_PCLK_STATE: st_d.rdat = st_q.pclk;
					`A_CLK_SETUP:  st_d.rdat = st_q.cgm;
					`A_PWR_SETUP:  st_d.rdat = {24'h0, st_q.pmr};
					`A_CLK_STATUS: st_d.rdat = {30'h0, st_q.lock, st_q.osc_ok};
					default:       st_d.rdat = 32'h0;
				endcase
			end
			if (wr) begin
				unique case (wb_i.adr)
					`A_PCLK_ENABLE:  st_d.pclk = st_q.pclk | (wdat & `PERIPH_MASK);
					`A_PCLK_DISABLE: st_d.pclk = st_q.pclk & ~wdat;
					`A_CLK_SETUP:    st_d.cgm  = cgm_new;
					`A_PWR_SETUP:    st_d.pmr  = pmr_word[7:0]; // only the low byte is stored
					default:         st_d.pclk = st_q.pclk;
				endcase
			end

			// slow clock divided by eight paces the oscillator counter
			if (slow_tick) begin
				st_d.div8 = st_q.div8 + 3'h1;
			end
			if (!st_d.cgm.osc_run_en) begin
				st_d.osc_cnt = 8'h0;
			end else if (osc_load) begin
				st_d.osc_cnt = cgm_new.osc_settle_count;
			end else if (osc_tick && st_q.osc_cnt != 8'h0) begin
				st_d.osc_cnt = st_q.osc_cnt - 8'h1;
			end
			st_d.osc_ok = st_d.cgm.osc_run_en && st_d.osc_cnt == 8'h0;

			// pll counter runs on every rising slow edge; factor zero clears lock
			if (st_d.cgm.pll_factor == 6'h0) begin
				st_d.pll_cnt = 6'h0;
			end else if (pll_load) begin
				st_d.pll_cnt = cgm_new.pll_settle_count;
			end else if (slow_tick && st_q.pll_cnt != 6'h0) begin
				st_d.pll_cnt = st_q.pll_cnt - 6'h1;
			end
			st_d.lock = st_d.cgm.pll_factor != 6'h0 && st_d.pll_cnt == 6'h0
				&& (st_d.osc_ok || st_d.cgm.osc_bypass_sel);

			if (wake_ev) begin
				st_d.cut = CUT_WAKE;
			end else if (cut_ev) begin
				st_d.cut = CUT_OFF;
			end
		end
		if (rst_i) begin
			st_d.ack     = 1'b0;
			st_d.rdat    = 32'h0;
			st_d.pclk    = 32'h0;
			st_d.cgm     = '0;
			st_d.div8    = 3'h0;
			st_d.osc_cnt = 8'h0;
			st_d.pll_cnt = 6'h0;
			st_d.osc_ok  = 1'b0;
			st_d.lock    = 1'b0;
		end
		if (bkup_rst_i) begin
			st_d.pmr = `PWR_SETUP_BKUP;
			st_d.cut = CUT_WAKE;
		end
		// pin drive registered from the settled state and selections
		if (st_d.cut == CUT_OFF) begin
			drv = level_drive(st_d.pmr.power_cut_level_sel);
		end else begin
			drv = level_drive(st_d.pmr.wake_level_sel);
		end
		st_d.cut_oe  = drv[1];
		st_d.cut_lvl = drv[0];
	end

	always_ff @(posedge clk_i) begin
		st_q <= st_d;
	end

	// outputs from state flops; pll_on_o and mclk_out_pin_oe_o pass through one gate each
	assign wb_o.ack           = st_q.ack;
	assign wb_o.dat           = st_q.rdat;
	assign periph_clk_en_o    = st_q.pclk;
	assign osc_run_en_o       = st_q.cgm.osc_run_en;
	assign osc_bypass_sel_o   = st_q.cgm.osc_bypass_sel;
	assign pll_on_o           = st_q.cgm.pll_factor != 6'h0;
	assign pll_factor_o       = st_q.cgm.pll_factor;
	assign clk_src_sel_o      = st_q.cgm.clk_src_sel;
	assign mclk_out_pin_o     = master_clk_o;
	assign mclk_out_pin_oe_o  = ~st_q.cgm.mclk_out_off;
	assign osc_stable_flag_o  = st_q.osc_ok;
	assign pll_lock_o         = st_q.lock;
	assign power_cut_pin_o    = st_q.cut_lvl;
	assign power_cut_pin_oe_o = st_q.cut_oe;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i || bkup_rst_i);

	property p_pclk_stop;
		(ce_i && wr && wb_i.adr == `A_PCLK_DISABLE) |=> ((st_q.pclk & $past(wdat)) == 32'h0);
	endproperty
	a_pclk_stop: assert property (p_pclk_stop) else $error("disable write left clock running");

	property p_pclk_keep;
		(ce_i && wr && wb_i.adr == `A_PCLK_DISABLE)
			|=> ((st_q.pclk & ~$past(wdat)) == ($past(st_q.pclk) & ~$past(wdat)));
	endproperty
	a_pclk_keep: assert property (p_pclk_keep) else $error("zero bits of disable changed a clock");

	property p_pclk_read;
		(ce_i && req && !wb_i.we && wb_i.adr == `A_PCLK_STATE) |=> wb_o.ack && wb_o.dat == $past(st_q.pclk);
	endproperty
	a_pclk_read: assert property (p_pclk_read) else $error("clock state read wrong");

	property p_osc_load;
		(ce_i && osc_load) |=> st_q.osc_cnt == $past(cgm_new.osc_settle_count) && !osc_stable_flag_o;
	endproperty
	a_osc_load: assert property (p_osc_load) else $error("oscillator counter not loaded");

	property p_pll_load;
		(ce_i && pll_load) |=> st_q.pll_cnt == $past(cgm_new.pll_settle_count) && !pll_lock_o;
	endproperty
	a_pll_load: assert property (p_pll_load) else $error("pll counter not reloaded");

	property p_lock_rise;
		$rose(pll_lock_o) |-> st_q.pll_cnt == 6'h0 && pll_on_o && $past(st_q.pll_cnt) <= 6'h1;
	endproperty
	a_lock_rise: assert property (p_lock_rise) else $error("lock without counter at zero");

	property p_wake_wins;
		(ce_i && wr && wb_i.adr == `A_PWR_CMD && wdat[`PCR_WAKE_BIT] && wdat[`PCR_CUT_BIT])
			|=> st_q.cut == CUT_WAKE;
	endproperty
	a_wake_wins: assert property (p_wake_wins) else $error("cut beat wake command");

	property p_cut_cmd;
		(ce_i && wr && wb_i.adr == `A_PWR_CMD && wdat[`PCR_CUT_BIT] && !wake_ev)
			|=> st_q.cut == CUT_OFF;
	endproperty
	a_cut_cmd: assert property (p_cut_cmd) else $error("cut command ignored");

	property p_cut_high;
		(st_q.cut == CUT_OFF && st_q.pmr.power_cut_level_sel == `LVL_HIGH)
			|-> power_cut_pin_oe_o && power_cut_pin_o;
	endproperty
	a_cut_high: assert property (p_cut_high) else $error("cut level high not driven");

	property p_alarm_cut;
		(ce_i && alarm_ev && st_q.pmr.alarm_wake_en) |=> st_q.cut == CUT_WAKE;
	endproperty
	a_alarm_cut: assert property (p_alarm_cut) else $error("alarm cut despite wake enable");

	property p_bkup;
		@(posedge clk_i) disable iff (rst_i) bkup_rst_i |=> st_q.pmr == `PWR_SETUP_BKUP && !power_cut_pin_oe_o;
	endproperty
	a_bkup: assert property (p_bkup) else $error("backup reset left pin driven");

	property p_wo_read;
		(ce_i && req && !wb_i.we && (wb_i.adr == `A_PWR_CMD || wb_i.adr == `A_PCLK_DISABLE))
			|=> wb_o.dat == 32'h0 && $stable(st_q.pclk);
	endproperty
	a_wo_read: assert property (p_wo_read) else $error("write-only read not zero");

	c_cut_then_wake: cover property ((st_q.cut == CUT_OFF) ##[1:50] (st_q.cut == CUT_WAKE));
	c_lock:          cover property ($rose(pll_lock_o));
	c_osc_ok:        cover property ($rose(osc_stable_flag_o));
endmodule : clock_gen_power_shutdown_ctrl

// file: supply_model.sv
// model of the external supply's shutdown input, with its resistor
// assumes the cut pin is split into value and drive enable
`timescale 1ns/1ps
module supply_model #(
	parameter logic PULL_LVL = 1'b1
) (
	input  wire logic pin_i,
	input  wire logic oe_i,
	output logic      line_o,
	output logic      supply_on_o
);
	// an undriven line rests at the resistor level, no keeper
	assign line_o = oe_i ? pin_i : PULL_LVL;
	// shutdown input is active low, so a low line stops the supply
	assign supply_on_o = line_o;
endmodule : supply_model

// file: test_clock_gen_power_shutdown_ctrl.sv
// self-checking bench of the clock and power bank
// assumes clk_pwr_pkg compiled first; slow clock runs fast to keep the run short
`timescale 1ns/1ps
`include "clk_pwr_cfg.svh"
module test_clock_gen_power_shutdown_ctrl;
	import clk_pwr_pkg::*;
	logic        clk_i, rst_i, bkup_rst_i, slow_i, osc_i, wake_i, alarm_i;
	wb_req_type  req;
	wb_rsp_type  rsp;
	logic [31:0] pclk, st, en, rng, expq[$];
	logic        osc_en, byp, pll_on, mclk, mpin, moe, stable, lock, cut, cut_oe, line, sup_on, s_q, o_q;
	logic [5:0]  fac;
	logic [1:0]  src;
	logic        ce, m0;
	int          fails, n_checks, cyc_n, n_slow, n_osc, n_tick, i, k, s0, n_chg;

	clock_gen_power_shutdown_ctrl i_clock_gen_power_shutdown_ctrl (
		.clk_i(clk_i), .rst_i(rst_i), .bkup_rst_i(bkup_rst_i), .ce_i(ce), .wb_i(req), .wb_o(rsp),
		.slow_clk_i(slow_i), .osc_in_pin_i(osc_i), .wake_pin_i(wake_i), .rtc_alarm_i(alarm_i),
		.periph_clk_en_o(pclk), .osc_run_en_o(osc_en), .osc_bypass_sel_o(byp), .pll_on_o(pll_on),
		.pll_factor_o(fac), .clk_src_sel_o(src), .master_clk_o(mclk), .mclk_out_pin_o(mpin),
		.mclk_out_pin_oe_o(moe), .osc_stable_flag_o(stable), .pll_lock_o(lock),
		.power_cut_pin_o(cut), .power_cut_pin_oe_o(cut_oe));
	supply_model i_supply_model (.pin_i(cut), .oe_i(cut_oe), .line_o(line), .supply_on_o(sup_on));

	// core clock, and free running slow and oscillator clocks out of phase with it
	initial begin clk_i = 0; forever #12.5 clk_i = ~clk_i; end
	initial begin slow_i = 0; forever #500 slow_i = ~slow_i; end
	initial begin osc_i = 0; forever #50 osc_i = ~osc_i; end

	function automatic logic [31:0] xorshift();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xorshift

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : test_done

	// classic cycle: hold until ack sampled, then release for a cycle
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		@(posedge clk_i);
		if (!we) expq.push_back(e);
		req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
		do @(posedge clk_i); while (rsp.ack !== 1'b1);
		req <= '0;
	endtask : wb

	// cut pin as {oe, value, line}; pin edges need a few cycles to land
	task automatic pin_is(input logic [1:0] lv);
		logic [1:0] e;
		e = (lv == `LVL_LOW) ? 2'b10 : (lv == `LVL_HIGH) ? 2'b11 : 2'b00;
		@(posedge clk_i);
		for (k = 0; k < 12 && {cut_oe, cut_oe & cut} !== e; k++) @(posedge clk_i);
		chk({cut_oe, cut_oe & cut, line}, {e, e[1] ? e[0] : 1'b1});
	endtask : pin_is

	// ticks per source event over a fixed window; divider phase allows one off
	task automatic measure(input logic [1:0] s, input logic [2:0] n);
		int e0, t0, ev, tk, ex;
		wb(1'b1, `A_CLK_SETUP, {16'h0, s, 6'h0, 1'b0, n, 3'h0, s == `SRC_MOSC}, 0);
		repeat (8) @(posedge clk_i);
		e0 = (s == `SRC_LF) ? n_slow : n_osc;
		t0 = n_tick;
		repeat (2600) @(posedge clk_i);
		ev = ((s == `SRC_LF) ? n_slow : n_osc) - e0;
		tk = n_tick - t0;
		ex = (n == `CLK_DIVIDER_SEL_RSVD || s == 2'b11) ? 0 : ev >> n;
		chk(tk + 1 >= ex && tk <= ex + 1, 1);
		chk({moe, mpin === mclk, src}, {2'b11, s});
	endtask : measure

	// read answers are compared with the oldest note in order
	always @(posedge clk_i) begin
		if (rsp.ack === 1'b1 && req.cyc && !req.we) chk(rsp.dat, expq.pop_front());
	end

	// edge and tick counters, and the hang limit
	always @(posedge clk_i) begin
		s_q <= slow_i;
		o_q <= osc_i;
		if (slow_i && !s_q) n_slow++;
		if (osc_i && !o_q) n_osc++;
		if (mclk === 1'b1) n_tick++;
		cyc_n++;
		if (cyc_n >= 90000) begin
			fails++;
			test_done();
		end
	end

	initial begin
		rng = 72;
		req = '0;
		ce = 1;
		rst_i = 1;
		bkup_rst_i = 1;
		wake_i = 0;
		alarm_i = 0;
		st = 0;
		repeat (4) @(posedge clk_i);
		rst_i <= 0;
		bkup_rst_i <= 0;
		wb(0, `A_PCLK_STATE, 0, 0);
		wb(0, `A_CLK_SETUP, 0, 0);
		wb(0, `A_PWR_SETUP, 0, 32'h1);
		wb(0, `A_PCLK_DISABLE, 0, 0);
		wb(0, `A_PWR_CMD, 0, 0);
		wb(0, 8'h3c, 0, 0);
		pin_is(`LVL_FLOAT);
		$display("test reset values done");
		// random gating, zeros in the disable word must leave clocks alone
		for (i = 0; i < 6; i++) begin
			en = xorshift() & `PERIPH_MASK;
			wb(1, `A_PCLK_ENABLE, en, 0);
			st = st | en;
			en = xorshift();
			wb(1, `A_PCLK_DISABLE, en, 0);
			st = st & ~en;
			wb(0, `A_PCLK_STATE, 0, st);
			chk(pclk, st);
		end
		$display("test gating done");
		// osc count 2, pll count 2, factor 3; lock waits for the oscillator
		wb(1, `A_CLK_SETUP, 32'h02020302, 0);
		wb(0, `A_CLK_SETUP, 0, 32'h02020302);
		wb(0, `A_CLK_STATUS, 0, 0);
		chk({osc_en, byp, pll_on, fac}, {3'b101, 6'h03});
		repeat (1100) @(posedge clk_i);
		wb(0, `A_CLK_STATUS, 0, 32'h3);
		chk({stable, lock}, 2'b11);
		wb(1, `A_CLK_SETUP, 32'h02020002, 0);
		wb(0, `A_CLK_STATUS, 0, 32'h1);
		wb(1, `A_CLK_SETUP, 32'h00000001, 0);
		wb(0, `A_CLK_STATUS, 0, 0);
		chk({osc_en, byp, pll_on}, 3'b010);
		$display("test oscillator and pll done");
		// bypass only, never with the oscillator enabled
		measure(`SRC_LF, 3'h0);
		measure(`SRC_LF, 3'h2);
		measure(`SRC_MOSC, 3'h3);
		measure(`SRC_MOSC, `CLK_DIVIDER_SEL_RSVD);
		measure(2'b11, 3'h1);
		$display("test prescaler done");
		// cut low, wake high
		wb(1, `A_PWR_SETUP, 32'h09, 0);
		wb(1, `A_PWR_CMD, 32'h1, 0);
		pin_is(`LVL_LOW);
		chk(sup_on, 0);
		wb(1, `A_PWR_CMD, 32'h2, 0);
		pin_is(`LVL_HIGH);
		wb(1, `A_PWR_CMD, 32'h1, 0);
		wb(1, `A_PWR_CMD, 32'h3, 0);
		pin_is(`LVL_HIGH);
		wb(1, `A_PWR_SETUP, 32'h29, 0);
		alarm_i <= 1'b1;
		pin_is(`LVL_LOW);
		alarm_i <= 1'b0;
		wb(1, `A_PWR_SETUP, 32'h39, 0);
		repeat (8) @(posedge clk_i);
		alarm_i <= 1'b1;
		pin_is(`LVL_HIGH);
		alarm_i <= 1'b0;
		// falling edge only: a rise must not wake
		wb(1, `A_PWR_SETUP, 32'h89, 0);
		wb(1, `A_PWR_CMD, 32'h1, 0);
		wake_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		pin_is(`LVL_LOW);
		wake_i <= 1'b0;
		pin_is(`LVL_HIGH);
		$display("test power cut done");
		// enable low freezes the ticking prescaler and the pin
		wb(1, `A_CLK_SETUP, 32'h0, 0);
		repeat (100) @(posedge clk_i);
		ce <= 1'b0;
		@(posedge clk_i);
		m0 = mclk;
		n_chg = 0;
		repeat (200) begin
			@(posedge clk_i);
			if (mclk !== m0 || cut_oe !== 1'b1) n_chg++;
		end
		chk(n_chg, 0);
		ce <= 1'b1;
		$display("test clock enable done");
		// main reset mid run leaves power setup alone
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, `A_CLK_SETUP, 0, 0);
		wb(0, `A_PCLK_STATE, 0, 0);
		wb(0, `A_PWR_SETUP, 0, 32'h89);
		pin_is(`LVL_HIGH);
		bkup_rst_i <= 1'b1;
		@(posedge clk_i);
		bkup_rst_i <= 1'b0;
		wb(0, `A_PWR_SETUP, 0, 32'h1);
		pin_is(`LVL_FLOAT);
		$display("test resets done");
		test_done();
	end
endmodule : test_clock_gen_power_shutdown_ctrl
